// ===== rtl/irq_enable_pkg.sv
// Package with constants and carrier types for the interrupt enable gate
package irq_enable_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ENABLE_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] FLAG_OFFSET = 4'h1;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h2;
  localparam logic [ADDR_W-1:0] MASK_OFFSET = 4'h3;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int EXT0_BIT = 0;
  localparam int TIMER0_BIT = 1;
  localparam int EXT1_BIT = 2;
  localparam int TIMER1_BIT = 3;
  localparam int NUM_SRC = 4;
  localparam logic [NUM_SRC-1:0] ENABLE_RESET = 4'h0;
  localparam logic [NUM_SRC-1:0] MASK_RESET = 4'h0;
  localparam logic [NUM_SRC-1:0] STATUS_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic timer1_overflow_flag;
    logic ext_irq1_input_n;
    logic timer0_overflow_flag;
    logic ext_irq0_input_n;
  } irq_src_type;

endpackage

// ===== rtl/irq_enable_gate.sv
// Interrupt enable gate for timer and external interrupt sources
//
// Summary of operation
// [RULE1] Bit 3 gates timer one overflow requests
// [RULE2] Bit 2 gates active-low external interrupt one
// [RULE3] Bit 1 gates timer zero overflow requests
// [RULE4] Bit 0 gates external interrupt zero
// [RULE5] Masking only gates; source flags stay untouched
`timescale 1ns/1ps

module irq_enable_gate (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // Register port
  input wire irq_enable_pkg::reg_req_type i_req,
  output logic [irq_enable_pkg::DATA_W-1:0] o_rdata,
  // Interrupt sources
  input wire irq_enable_pkg::irq_src_type i_src,
  // Gated requests toward the core
  output logic [irq_enable_pkg::NUM_SRC-1:0] o_irq_req,
  output logic o_irq
);
  import irq_enable_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Request lines and gating
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] raw;
  logic [NUM_SRC-1:0] enable_q, enable_d;
  logic [NUM_SRC-1:0] mask_q, mask_d;
  logic [NUM_SRC-1:0] status_q, status_d;
  logic [NUM_SRC-1:0] req_d;
  logic [NUM_SRC-1:0] req_q;
  logic irq_q, irq_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [NUM_SRC-1:0] wbits;

  // Timer flags pass through unaltered and the active-low external inputs are inverted; the gate never writes them back
  always_comb begin
    raw[TIMER1_BIT] = i_src.timer1_overflow_flag; // RULE5
    raw[EXT1_BIT] = ~i_src.ext_irq1_input_n;
    raw[TIMER0_BIT] = i_src.timer0_overflow_flag;
    raw[EXT0_BIT] = ~i_src.ext_irq0_input_n;
  end

  always_comb begin
    req_d = '0;
    req_d[TIMER1_BIT] = raw[TIMER1_BIT] & enable_q[TIMER1_BIT]; // RULE1
    req_d[EXT1_BIT] = raw[EXT1_BIT] & enable_q[EXT1_BIT]; // RULE2
    req_d[TIMER0_BIT] = raw[TIMER0_BIT] & enable_q[TIMER0_BIT]; // RULE3
    req_d[EXT0_BIT] = raw[EXT0_BIT] & enable_q[EXT0_BIT]; // RULE4
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_comb begin
    wbits = i_req.wdata[NUM_SRC-1:0];
    enable_d = enable_q;
    mask_d = mask_q;
    if (i_req.wr && i_req.addr == ENABLE_OFFSET) begin
      enable_d = wbits;
    end
    if (i_req.wr && i_req.addr == MASK_OFFSET) begin
      mask_d = wbits;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      enable_q <= ENABLE_RESET;
      mask_q <= MASK_RESET;
    end else begin
      enable_q <= enable_d;
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------------------------------
  // Gated requests, sticky status and interrupt level
  // ----------------------------------------------------------------
  always_comb begin
    // Write one clears; a new gated request wins over the clear
    status_d = status_q;
    if (i_req.wr && i_req.addr == STATUS_OFFSET) begin
      status_d = status_q & ~wbits;
    end
    status_d = status_d | req_q;
    // Taken from the next values so the level never lags the status
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      req_q <= '0;
      status_q <= STATUS_RESET;
      irq_q <= 1'b0;
    end else begin
      req_q <= req_d;
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    // Idle cycles read zero so stale data is never taken for an answer
    rdata_d = '0;
    if (i_req.rd) begin
      case (i_req.addr)
        ENABLE_OFFSET: rdata_d = {{(DATA_W-NUM_SRC){1'b0}}, enable_q};
        FLAG_OFFSET: rdata_d = {{(DATA_W-NUM_SRC){1'b0}}, raw};
        STATUS_OFFSET: rdata_d = {{(DATA_W-NUM_SRC){1'b0}}, status_q};
        MASK_OFFSET: rdata_d = {{(DATA_W-NUM_SRC){1'b0}}, mask_q};
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_irq_req = req_q;
  assign o_irq = irq_q;
  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!rst_n_q);

  chk_timer1_gate: assert property ( // RULE1
    o_irq_req[TIMER1_BIT] == $past(raw[TIMER1_BIT] & enable_q[TIMER1_BIT]))
    else $error("timer one request gating wrong");
  chk_ext1_gate: assert property ( // RULE2
    (!enable_q[EXT1_BIT] || i_src.ext_irq1_input_n) |=> !o_irq_req[EXT1_BIT])
    else $error("external one passed while blocked");
  chk_ext1_pass: assert property ( // RULE2
    (enable_q[EXT1_BIT] && !i_src.ext_irq1_input_n) |=> o_irq_req[EXT1_BIT])
    else $error("external one not forwarded");
  chk_timer0_gate: assert property ( // RULE3
    o_irq_req[TIMER0_BIT] == $past(raw[TIMER0_BIT] & enable_q[TIMER0_BIT]))
    else $error("timer zero request gating wrong");
  chk_ext0_gate: assert property ( // RULE4
    o_irq_req[EXT0_BIT] == $past(raw[EXT0_BIT] & enable_q[EXT0_BIT]))
    else $error("external zero request gating wrong");
  chk_flag_visible: assert property ( // RULE5
    (i_req.rd && i_req.addr == FLAG_OFFSET) |=>
      o_rdata[NUM_SRC-1:0] == $past(raw))
    else $error("flag read altered by enable");
  chk_status_sticky: assert property (
    (req_q != '0) |=> ((status_q & $past(req_q)) == $past(req_q)))
    else $error("status lost an event");
  chk_irq_level: assert property (
    o_irq == |(status_q & mask_q))
    else $error("interrupt level wrong");
  chk_timer1_block: assert property ( // RULE1
    !enable_q[TIMER1_BIT] |=> !o_irq_req[TIMER1_BIT])
    else $error("timer one passed while blocked");
  chk_timer0_block: assert property ( // RULE3
    !enable_q[TIMER0_BIT] |=> !o_irq_req[TIMER0_BIT])
    else $error("timer zero passed while blocked");
  chk_ext0_block: assert property ( // RULE4
    (!enable_q[EXT0_BIT] || i_src.ext_irq0_input_n) |=> !o_irq_req[EXT0_BIT])
    else $error("external zero passed while blocked");
  chk_ext0_pass: assert property ( // RULE4
    (enable_q[EXT0_BIT] && !i_src.ext_irq0_input_n) |=> o_irq_req[EXT0_BIT])
    else $error("external zero not forwarded");
  chk_status_from_req: assert property (
    (status_q & ~$past(status_q) & ~$past(req_q)) == '0)
    else $error("status set without a gated request");
  chk_status_clear: assert property (
    (i_req.wr && i_req.addr == STATUS_OFFSET && req_q == '0) |=>
      (status_q & $past(i_req.wdata[NUM_SRC-1:0])) == '0)
    else $error("status bit survived its clear");
  chk_enable_write: assert property (
    (i_req.wr && i_req.addr == ENABLE_OFFSET) |=>
      enable_q == $past(i_req.wdata[NUM_SRC-1:0]))
    else $error("enable write not taken");
  chk_mask_write: assert property (
    (i_req.wr && i_req.addr == MASK_OFFSET) |=>
      mask_q == $past(i_req.wdata[NUM_SRC-1:0]))
    else $error("mask write not taken");
  chk_rdata_idle: assert property (
    !i_req.rd |=> o_rdata == '0)
    else $error("read data not cleared after read");
  chk_rdata_upper: assert property (
    o_rdata[DATA_W-1:NUM_SRC] == '0)
    else $error("unused read bits not zero");
  chk_unmapped_write: assert property (
    (i_req.wr && i_req.addr > MASK_OFFSET) |=>
      (enable_q == $past(enable_q) && mask_q == $past(mask_q)))
    else $error("write to a free address changed state");
  chk_unmapped_read: assert property (
    (i_req.rd && i_req.addr > MASK_OFFSET) |=> o_rdata == '0)
    else $error("free address read not zero");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  cov_timer1: cover property (enable_q[TIMER1_BIT] && raw[TIMER1_BIT]);
  cov_ext1_blocked: cover property (!enable_q[EXT1_BIT] && raw[EXT1_BIT]);
  cov_irq: cover property (o_irq);
  cov_clear: cover property (i_req.wr && i_req.addr == STATUS_OFFSET);
  cov_set_wins: cover property (
    i_req.wr && i_req.addr == STATUS_OFFSET && (req_q & wbits) != '0);

endmodule

// ===== test/irq_enable_gate_tb_top.sv
// Self-checking bench for the interrupt enable gate
`timescale 1ns/1ps

module irq_enable_gate_tb_top;
  import irq_enable_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  reg_req_type i_req = '0;
  irq_src_type i_src = 4'h5;
  logic [DATA_W-1:0] o_rdata;
  logic [NUM_SRC-1:0] o_irq_req;
  logic o_irq;
  logic rd_seen = 1'b0;
  logic look = 1'b0;
  logic [7:0] irq_seen;
  logic [31:0] seed = 32'h79F3;
  logic [7:0] rd_q[$];
  logic [4:0] irq_q[$];
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  irq_enable_gate dut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_req(i_req), .o_rdata(o_rdata), .i_src(i_src),
    .o_irq_req(o_irq_req), .o_irq(o_irq));

  always #20 i_clk_sys = ~i_clk_sys;

  // ------------------------------------------
  // Helpers
  // ------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    i_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
  endtask

  task automatic idle();
    i_req <= '0;
    @(posedge i_clk_sys);
  endtask

  // ------------------------------------------
  // Monitor and timeout
  // ------------------------------------------
  always @(posedge i_clk_sys) begin
    rd_seen <= i_req.rd;
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      print_verdict();
    end
  end

  always @(negedge i_clk_sys) begin
    if (rd_seen) check(o_rdata, rd_q.pop_front());
    if (look) begin
      irq_seen = {3'h0, o_irq, o_irq_req};
      check(irq_seen, {3'h0, irq_q.pop_front()});
    end
  end

  initial begin
    logic [3:0] en, act, msk;
    repeat (8) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    rd(ENABLE_OFFSET, 8'h00);
    rd(4'hF, 8'h00);
    idle();
    $display("test reset and unmapped done");
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      en = seed[3:0];
      msk = seed[7:4];
      act = seed[11:8] ^ 4'h5;
      wr(ENABLE_OFFSET, {4'h0, en});
      wr(MASK_OFFSET, {4'h0, msk});
      wr(STATUS_OFFSET, 8'h0F);
      i_src <= seed[11:8];
      idle();
      repeat (2) @(posedge i_clk_sys);
      irq_q.push_back({|(en & act & msk), en & act});
      look <= 1'b1;
      @(posedge i_clk_sys);
      look <= 1'b0;
      rd(FLAG_OFFSET, {4'h0, act});
      rd(STATUS_OFFSET, {4'h0, en & act});
      rd(ENABLE_OFFSET, {4'h0, en});
      rd(MASK_OFFSET, {4'h0, msk});
      i_src <= 4'h5;
      idle();
      repeat (2) @(posedge i_clk_sys);
    end
    $display("test random gating done");
    // Reset in mid-run with every source active
    wr(ENABLE_OFFSET, 8'h0F);
    wr(MASK_OFFSET, 8'h0F);
    i_src <= 4'hA;
    idle();
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    irq_q.push_back(5'h00);
    look <= 1'b1;
    rd(ENABLE_OFFSET, 8'h00);
    look <= 1'b0;
    rd(MASK_OFFSET, 8'h00);
    rd(STATUS_OFFSET, 8'h00);
    rd(FLAG_OFFSET, 8'h0F);
    $display("test mid-run reset done");
    // Set beats clear, partial clear, mask and free addresses
    wr(ENABLE_OFFSET, 8'h0F);
    idle();
    wr(STATUS_OFFSET, 8'h0F);
    rd(STATUS_OFFSET, 8'h0F);
    i_src <= 4'h5;
    wr(MASK_OFFSET, 8'h04);
    wr(STATUS_OFFSET, 8'h03);
    irq_q.push_back(5'h10);
    look <= 1'b1;
    rd(STATUS_OFFSET, 8'h0C);
    look <= 1'b0;
    wr(4'h9, 8'h00);
    wr(FLAG_OFFSET, 8'h00);
    rd(ENABLE_OFFSET, 8'h0F);
    rd(MASK_OFFSET, 8'h04);
    idle();
    $display("test status and mask done");
    print_verdict();
  end
endmodule
